// >>> rtc_event_pkg.sv
// Function
// RL1: Two alarm register sets, 0Ah-0Eh and 14h-18h, match month, date, hour, minute, second.
// RL2: Five repeat bits pick rate: all ones per second, all zeros once per year.
// RL3: Undefined repeat codes act as the once-per-second rate.
// RL4: An alarm match under its repeat code sets that alarm's flag.
// RL5: With first_alarm_irq_enable set, an alarm condition asserts the interrupt pin.
// RL6: Pointer resting on the flags address suppresses alarm flags and interrupts.
// RL7: Reading flags at 0Fh releases the alarm interrupt; cleared flag shows next read.
// RL8: Bit D1 of 13h enables the second alarm at 14h-18h.
// RL9: Second alarm enable resets to zero; 14h-18h then act as plain storage.
// RL10: Watchdog 09h holds five-bit multiplier above a two-bit resolution field.
// RL11: Timeout is multiplier times resolution; writes restart; expiry sets flag and pin.
// RL12: Host writes 00h after expiry to release the pin; watchdog stays disabled.
// RL13: Reading flags clears the watchdog flag D7 and countdown flag D3.
// RL14: Reset clears the watchdog register, so the watchdog starts disabled.
// RL15: Eight-bit down-counter at 10h, enabled by D7 of control register 11h.
// RL16: Clock select: 00 4096 Hz, 01 64 Hz, 10 1 Hz, 11 1/60 Hz.
// RL17: Each countdown end sets the flag, reloads the count and keeps counting.
// RL18: Loaded count zero stops the timer; n gives period n over source rate.
// RL19: Level mode: pin active while flag and irq enable are both set.
// RL20: Pulse length follows source rate and n, from 1/8192 s up to 1/64 s.
// RL21: In pulse mode clearing the flag does not stop pulses; control bits do.
// RL22: Reset clears countdown enable; re-enabling resumes from the held count.
// RL23: Reading the countdown value returns the live count.
// RL24: With no source enabled the pin follows bit D7 of register 08h.
// RL25: Pin is the active-low OR of every enabled source.
package rtc_event_pkg;
	// ==========================================================
	// Register map
	localparam logic [6:0] ADDR_OUT   = 7'h08;
	localparam logic [6:0] ADDR_WD    = 7'h09;
	localparam logic [6:0] ADDR_A1    = 7'h0a;
	localparam logic [6:0] ADDR_FLAGS = 7'h0f;
	localparam logic [6:0] ADDR_CNT   = 7'h10;
	localparam logic [6:0] ADDR_CTL   = 7'h11;
	localparam logic [6:0] ADDR_A2EN  = 7'h13;
	localparam logic [6:0] ADDR_A2    = 7'h14;
	localparam int         ALARM_REGS = 5;
	// ==========================================================
	// Field positions
	localparam int FLAG_WD   = 7;
	localparam int FLAG_A1   = 6;
	localparam int FLAG_A2   = 5;
	localparam int FLAG_CT   = 3;
	localparam int CTL_TE    = 7;
	localparam int CTL_PSEL  = 6;
	localparam int CTL_TIE   = 5;
	localparam int A2EN_BIT  = 1;
	localparam int OUT_BIT   = 7;
	localparam int FIRST_ALARM_IRQ_ENABLE_BIT  = 6;
	localparam int RPT_BIT   = 7;
	localparam int WD_MULT_H = 6;
	localparam int WD_MULT_L = 2;
	localparam int W_SEC     = 7;
	localparam int W_MIN     = 7;
	localparam int W_HOUR    = 6;
	localparam int W_DATE    = 6;
	localparam int W_MONTH   = 5;
	// ==========================================================
	// Reset values
	localparam logic [7:0] CTL_RST  = 8'h03;
	localparam logic [7:0] OUT_RST  = 8'h80;
	localparam logic [7:0] WD_RST   = 8'h00;
	localparam logic [7:0] A2EN_RST = 8'h00;
	// ==========================================================
	// Repeat codes, RPT5 down to RPT1
	localparam logic [4:0] RPT_SEC   = 5'h1f;
	localparam logic [4:0] RPT_MIN   = 5'h1e;
	localparam logic [4:0] RPT_HOUR  = 5'h1c;
	localparam logic [4:0] RPT_DAY   = 5'h18;
	localparam logic [4:0] RPT_MONTH = 5'h10;
	localparam logic [4:0] RPT_YEAR  = 5'h00;
	// ==========================================================
	// Timing, prescaler runs on 4096 Hz ticks
	localparam logic [1:0]  SRC_4096   = 2'h0;
	localparam logic [1:0]  SRC_64     = 2'h1;
	localparam logic [5:0]  LAST_64    = 6'h3f;
	localparam logic [11:0] LAST_1HZ   = 12'hfff;
	localparam logic [5:0]  LAST_MIN   = 6'h3b;
	localparam logic [3:0]  WD_SH_BASE = 4'h8;
	localparam int CLK_PERIOD_NS = 40;
	localparam int P8192_NS      = 1000000000 / 8192;
	localparam int P4096_NS      = 1000000000 / 4096;
	localparam int P128_NS       = 1000000000 / 128;
	localparam int P64_NS        = 1000000000 / 64;
	localparam int P8192_CYC     = P8192_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {PH_ADDR, PH_WRITE, PH_READ} spi_phase_e;
endpackage : rtc_event_pkg

// >>> sync2.sv
`timescale 1ns/1ns
module sync2 #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_chk
		$error("sync2 width must be positive");
	end

	// First stage feeds only the second one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta   <= RST_VAL;
			sync_o <= RST_VAL;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule : sync2

// >>> alarm_match.sv
`timescale 1ns/1ns
module alarm_match
	import rtc_event_pkg::*;
(
	input  wire logic [7:0] al_month_i,
	input  wire logic [7:0] al_date_i,
	input  wire logic [7:0] al_hour_i,
	input  wire logic [7:0] al_min_i,
	input  wire logic [7:0] al_sec_i,
	input  wire logic [7:0] cur_month_i,
	input  wire logic [7:0] cur_date_i,
	input  wire logic [7:0] cur_hour_i,
	input  wire logic [7:0] cur_min_i,
	input  wire logic [7:0] cur_sec_i,
	output logic            match_o
);
	logic [4:0] rpt;
	logic       s_eq, m_eq, h_eq, d_eq, mo_eq;

	// Field compares, flag bits above each field are ignored
	assign s_eq  = al_sec_i[W_SEC-1:0] == cur_sec_i[W_SEC-1:0];
	assign m_eq  = al_min_i[W_MIN-1:0] == cur_min_i[W_MIN-1:0];
	assign h_eq  = al_hour_i[W_HOUR-1:0] == cur_hour_i[W_HOUR-1:0];
	assign d_eq  = al_date_i[W_DATE-1:0] == cur_date_i[W_DATE-1:0];
	assign mo_eq = al_month_i[W_MONTH-1:0] == cur_month_i[W_MONTH-1:0];
	assign rpt   = {al_month_i[RPT_BIT], al_date_i[RPT_BIT], al_hour_i[RPT_BIT],
		al_min_i[RPT_BIT], al_sec_i[RPT_BIT]};

	// Each cleared repeat bit adds one field to the match
	always_comb begin
		case (rpt)
			RPT_SEC:   match_o = 1'b1; // see RL2
			RPT_MIN:   match_o = s_eq;
			RPT_HOUR:  match_o = s_eq & m_eq;
			RPT_DAY:   match_o = s_eq & m_eq & h_eq;
			RPT_MONTH: match_o = s_eq & m_eq & h_eq & d_eq;
			RPT_YEAR:  match_o = s_eq & m_eq & h_eq & d_eq & mo_eq; // see RL2
			// Bad codes fire every second so software notices quickly
			default:   match_o = 1'b1; // see RL3
		endcase
	end
endmodule : alarm_match

// >>> rtc_events.sv
`timescale 1ns/1ns
module rtc_events #(
	parameter int PULSE_4096_CYC = rtc_event_pkg::P4096_NS / rtc_event_pkg::CLK_PERIOD_NS,
	parameter int PULSE_128_CYC  = rtc_event_pkg::P128_NS / rtc_event_pkg::CLK_PERIOD_NS,
	parameter int PULSE_64_CYC   = rtc_event_pkg::P64_NS / rtc_event_pkg::CLK_PERIOD_NS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       spi_clk_i,
	input  wire logic       spi_data_i,
	input  wire logic       chip_enable_n_i,
	input  wire logic       osc_4096_i,
	input  wire logic [7:0] time_sec_i,
	input  wire logic [7:0] time_min_i,
	input  wire logic [7:0] time_hour_i,
	input  wire logic [7:0] time_date_i,
	input  wire logic [7:0] time_month_i,
	output logic            spi_data_o,
	output logic            spi_data_oe_o,
	output logic            interrupt_pin_o,
	output logic            interrupt_pin_oe_o
);
	import rtc_event_pkg::*;
	localparam int PW = 19;

	if (PULSE_4096_CYC < 1 || PULSE_128_CYC < 1 || PULSE_64_CYC >= 2 ** PW) begin : g_chk
		$error("pulse lengths out of range");
	end

	// ==========================================================
	// Pin synchronisers and edge detection
	logic       sclk_s, ce_n_s, sdi_s, osc_s, sclk_d, osc_d;
	logic       sck_rise, sck_fall, tick, ce;
	sync2 #(.WIDTH(4), .RST_VAL(4'h4)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i ({spi_clk_i, chip_enable_n_i, spi_data_i, osc_4096_i}),
		.sync_o  ({sclk_s, ce_n_s, sdi_s, osc_s})
	);

	// Previous levels for edge finding
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sclk_d <= 1'b0;
			osc_d  <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
			osc_d  <= osc_s;
		end
	end
	assign ce       = ~ce_n_s;
	assign sck_rise = ce & sclk_s & ~sclk_d;
	assign sck_fall = ce & ~sclk_s & sclk_d;
	assign tick     = osc_s & ~osc_d;

	// ==========================================================
	// Serial slave: address byte, then data bytes, pointer auto-increments
	spi_phase_e phase;
	logic [2:0] bit_cnt;
	logic [7:0] sh_in, sh_out, rx, rd_byte, shown;
	logic [6:0] ptr, ld_addr;
	logic       byte_done, rd_load, wr, flag_rd;
	logic [7:0] out_reg, wd_reg, ctl, a2en, cnt, reload;
	logic [7:0] al1 [ALARM_REGS];
	logic [7:0] al2 [ALARM_REGS];
	logic       wd_expired_flag, af1, af2, tf;

	assign rx        = {sh_in[6:0], sdi_s};
	assign byte_done = sck_rise & (bit_cnt == 3'h7);
	assign rd_load   = byte_done & ((phase == PH_ADDR & ~rx[7]) | phase == PH_READ);
	assign wr        = byte_done & (phase == PH_WRITE);
	assign ld_addr   = (phase == PH_ADDR) ? rx[6:0] : 7'(ptr + 7'h01);
	// Side effects land on the first clock of the byte, not the prefetch
	assign flag_rd   = sck_rise & (bit_cnt == 3'h0) & (phase == PH_READ) & (ptr == ADDR_FLAGS);

	// Bit counter, phase and pointer; pointer survives chip deselect
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bit_cnt <= 3'h0;
			phase   <= PH_ADDR;
			ptr     <= 7'h00;
			sh_in   <= 8'h00;
		end else if (!ce) begin
			bit_cnt <= 3'h0;
			phase   <= PH_ADDR;
		end else if (sck_rise) begin
			bit_cnt <= 3'(bit_cnt + 3'h1);
			sh_in   <= rx;
			if (byte_done) begin
				if (phase == PH_ADDR) begin
					ptr   <= rx[6:0];
					phase <= rx[7] ? PH_WRITE : PH_READ;
				end else begin
					ptr <= 7'(ptr + 7'h01);
				end
			end
		end
	end

	// Read data mux; live count is returned, not the reload value
	always_comb begin
		rd_byte = 8'h00;
		if (ld_addr >= ADDR_A1 && ld_addr < 7'(ADDR_A1 + ALARM_REGS))
			rd_byte = al1[3'(ld_addr - ADDR_A1)];
		else if (ld_addr >= ADDR_A2 && ld_addr < 7'(ADDR_A2 + ALARM_REGS))
			rd_byte = al2[3'(ld_addr - ADDR_A2)]; // see RL9
		else begin
			case (ld_addr)
				ADDR_OUT:   rd_byte = out_reg;
				ADDR_WD:    rd_byte = wd_reg;
				ADDR_FLAGS: rd_byte = {wd_expired_flag, af1, af2, 1'b0, tf, 3'h0};
				ADDR_CNT:   rd_byte = cnt; // see RL23
				ADDR_CTL:   rd_byte = ctl;
				ADDR_A2EN:  rd_byte = a2en;
				default:    rd_byte = 8'h00;
			endcase
		end
	end

	// Output shifter; first falling edge after a load keeps the MSB
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sh_out        <= 8'h00;
			shown         <= 8'h00;
			spi_data_oe_o <= 1'b0;
		end else begin
			spi_data_oe_o <= ce & (phase == PH_READ);
			if (rd_load) begin
				sh_out <= rd_byte;
				shown  <= {wd_expired_flag, af1, af2, 1'b0, tf, 3'h0};
			end else if (sck_fall && bit_cnt != 3'h0 && phase == PH_READ) begin
				sh_out <= {sh_out[6:0], 1'b0};
			end
		end
	end
	assign spi_data_o = sh_out[7];

	// ==========================================================
	// Register writes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			out_reg <= OUT_RST;
			wd_reg  <= WD_RST; // see RL14
			ctl     <= CTL_RST; // see RL22
			a2en    <= A2EN_RST; // see RL9
			for (int i = 0; i < ALARM_REGS; i++) begin
				al1[i] <= 8'h00;
				al2[i] <= 8'h00;
			end
		end else if (wr) begin
			case (ptr)
				ADDR_OUT:  out_reg <= rx;
				ADDR_WD:   wd_reg  <= rx; // see RL10
				ADDR_CTL:  ctl     <= rx; // see RL15
				ADDR_A2EN: a2en    <= rx; // see RL8
				default: begin
					if (ptr >= ADDR_A1 && ptr < 7'(ADDR_A1 + ALARM_REGS))
						al1[3'(ptr - ADDR_A1)] <= rx; // see RL1
					if (ptr >= ADDR_A2 && ptr < 7'(ADDR_A2 + ALARM_REGS))
						al2[3'(ptr - ADDR_A2)] <= rx; // see RL1
				end
			endcase
		end
	end

	// ==========================================================
	// Prescaler: 4096 Hz ticks down to 64 Hz, 1 Hz and one per minute
	logic [11:0] presc;
	logic [5:0]  min_cnt;
	logic        t64, t1, t60, src_tick;
	assign t64 = tick & (presc[5:0] == LAST_64);
	assign t1  = tick & (presc == LAST_1HZ);
	assign t60 = t1 & (min_cnt == LAST_MIN);

	// Free-running dividers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			presc   <= 12'h000;
			min_cnt <= 6'h00;
		end else if (tick) begin
			presc <= 12'(presc + 12'h001);
			if (t1)
				min_cnt <= t60 ? 6'h00 : 6'(min_cnt + 6'h01);
		end
	end

	// ==========================================================
	// Watchdog, counted in 4096 Hz ticks
	logic [PW-1:0] wd_cnt, wd_tgt;
	logic          wd_run, wd_irq, wd_wr, wd_expire;
	assign wd_wr     = wr & (ptr == ADDR_WD);
	assign wd_tgt    = PW'(wd_reg[WD_MULT_H:WD_MULT_L]) << (WD_SH_BASE + {wd_reg[1:0], 1'b0}); // see RL11
	assign wd_expire = wd_run & tick & ~wd_wr & (PW'(wd_cnt + 1'b1) >= wd_tgt);

	// Any write clears the count and restarts it if the multiplier is nonzero; expiry stops it until reprogrammed
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wd_cnt <= '0;
			wd_run <= 1'b0;
			wd_irq <= 1'b0;
		end else begin
			if (wd_wr) begin
				wd_cnt <= '0; // see RL11
				wd_run <= rx[WD_MULT_H:WD_MULT_L] != 5'h00;
			end else if (wd_expire) begin
				wd_run <= 1'b0; // see RL12
			end else if (wd_run && tick) begin
				wd_cnt <= PW'(wd_cnt + 1'b1);
			end
			if (wd_expire)
				wd_irq <= 1'b1; // see RL11
			else if (wd_wr && rx == 8'h00)
				wd_irq <= 1'b0; // see RL12
		end
	end

	// ==========================================================
	// Countdown timer
	logic          te, psel, countdown_irq_enable, cnt_wr, cnt_end, pulse_on;
	logic [PW-1:0] pcnt, plen;
	assign te     = ctl[CTL_TE];
	assign psel   = ctl[CTL_PSEL];
	assign countdown_irq_enable    = ctl[CTL_TIE];
	assign cnt_wr = wr & (ptr == ADDR_CNT);

	// Source select
	always_comb begin
		case (ctl[1:0])
			2'h0:    src_tick = tick; // see RL16
			2'h1:    src_tick = t64;
			2'h2:    src_tick = t1;
			default: src_tick = t60;
		endcase
	end
	assign cnt_end = src_tick & te & (reload != 8'h00) & (cnt <= 8'h01) & ~cnt_wr;

	// Pulse length; a count of one at high rates gives the short pulse
	always_comb begin
		if (ctl[1:0] == SRC_4096)
			plen = (reload == 8'h01) ? PW'(P8192_CYC) : PW'(PULSE_4096_CYC); // see RL20
		else if (ctl[1:0] == SRC_64)
			plen = (reload == 8'h01) ? PW'(PULSE_128_CYC) : PW'(PULSE_64_CYC);
		else
			plen = PW'(PULSE_64_CYC);
	end

	// Live count and reload; disabling holds the count where it is
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt    <= 8'h00;
			reload <= 8'h00;
		end else if (cnt_wr) begin
			cnt    <= rx;
			reload <= rx;
		end else if (cnt_end) begin
			cnt <= reload; // see RL17
		end else if (src_tick && te && reload != 8'h00) begin // see RL18
			cnt <= 8'(cnt - 8'h01); // see RL22
		end
	end

	// Pulse timer runs from each countdown end, whatever the flag does
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			pcnt <= '0;
		else if (cnt_end)
			pcnt <= plen;
		else if (pcnt != '0)
			pcnt <= PW'(pcnt - 1'b1);
	end
	assign pulse_on = (pcnt != '0) & psel & countdown_irq_enable & te; // see RL21

	// ==========================================================
	// Alarms, checked each time the seconds input changes
	logic [7:0] sec_prev;
	logic       m1, m2, new_sec, a1_set, a2_set, first_alarm_irq_enable, alarm_irq;
	alarm_match u_alarm1 (
		.al_month_i  (al1[0]),
		.al_date_i   (al1[1]),
		.al_hour_i   (al1[2]),
		.al_min_i    (al1[3]),
		.al_sec_i    (al1[4]),
		.cur_month_i (time_month_i),
		.cur_date_i  (time_date_i),
		.cur_hour_i  (time_hour_i),
		.cur_min_i   (time_min_i),
		.cur_sec_i   (time_sec_i),
		.match_o     (m1)
	);
	alarm_match u_alarm2 (
		.al_month_i  (al2[0]),
		.al_date_i   (al2[1]),
		.al_hour_i   (al2[2]),
		.al_min_i    (al2[3]),
		.al_sec_i    (al2[4]),
		.cur_month_i (time_month_i),
		.cur_date_i  (time_date_i),
		.cur_hour_i  (time_hour_i),
		.cur_min_i   (time_min_i),
		.cur_sec_i   (time_sec_i),
		.match_o     (m2)
	);
	assign first_alarm_irq_enable    = al1[0][FIRST_ALARM_IRQ_ENABLE_BIT];
	assign new_sec = time_sec_i != sec_prev;
	assign a1_set  = new_sec & m1 & (ptr != ADDR_FLAGS); // see RL4 see RL6
	assign a2_set  = new_sec & m2 & a2en[A2EN_BIT] & (ptr != ADDR_FLAGS); // see RL8

	// Flags: read clears only what the reader saw; a set in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sec_prev  <= 8'h00;
			{wd_expired_flag, af1, af2, tf} <= 4'h0;
			alarm_irq <= 1'b0;
		end else begin
			sec_prev <= time_sec_i;
			if (flag_rd) begin
				wd_expired_flag       <= wd_expired_flag & ~shown[FLAG_WD]; // see RL13
				af1       <= af1 & ~shown[FLAG_A1]; // see RL7
				af2       <= af2 & ~shown[FLAG_A2];
				tf        <= tf & ~shown[FLAG_CT]; // see RL13
				alarm_irq <= 1'b0; // see RL7
			end
			if (wd_expire)
				wd_expired_flag <= 1'b1;
			if (a1_set)
				af1 <= 1'b1;
			if (a2_set)
				af2 <= 1'b1;
			if (cnt_end)
				tf <= 1'b1; // see RL17
			if ((a1_set || a2_set) && first_alarm_irq_enable)
				alarm_irq <= 1'b1; // see RL5
		end
	end

	// ==========================================================
	// Open-drain interrupt pin, registered
	logic any_en, next_pin_low;
	assign any_en       = first_alarm_irq_enable | (wd_reg != 8'h00) | countdown_irq_enable;
	assign next_pin_low = alarm_irq | wd_irq | (tf & countdown_irq_enable & ~psel) | pulse_on // see RL19 see RL25
		| (~any_en & ~out_reg[OUT_BIT]); // see RL24

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			interrupt_pin_oe_o <= 1'b0;
		else
			interrupt_pin_oe_o <= next_pin_low;
	end
	assign interrupt_pin_o = 1'b0;

	// ==========================================================
	// Checks
	property p_ptr_suppress;
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(af1) |-> $past(ptr) != ADDR_FLAGS;
	endproperty
	a_ptr_suppress: assert property (p_ptr_suppress) else $error("alarm flag set on flags pointer"); // see RL6

	property p_alarm_release;
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_rd && !a1_set && !a2_set) |=> !alarm_irq ##1 !interrupt_pin_oe_o || wd_irq || any_en;
	endproperty
	a_alarm_release: assert property (p_alarm_release) else $error("alarm irq not released"); // see RL7

	property p_flag_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_rd && shown[FLAG_WD] && !wd_expire) |=> !wd_expired_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("watchdog flag not cleared"); // see RL13

	property p_wd_expire;
		@(posedge clk_i) disable iff (!rst_n_i)
		wd_expire |=> wd_expired_flag && wd_irq && !wd_run ##1 interrupt_pin_oe_o;
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry not signalled"); // see RL11

	property p_wd_release;
		@(posedge clk_i) disable iff (!rst_n_i)
		(wd_wr && rx == 8'h00) |=> !wd_irq && !wd_run;
	endproperty
	a_wd_release: assert property (p_wd_release) else $error("watchdog not released by zero"); // see RL12

	property p_reload;
		@(posedge clk_i) disable iff (!rst_n_i)
		cnt_end |=> cnt == $past(reload) && tf && pcnt == $past(plen);
	endproperty
	a_reload: assert property (p_reload) else $error("countdown did not reload"); // see RL17

	property p_stopped;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reload == 8'h00 && !cnt_wr) |=> $stable(cnt) && !tf || $past(tf);
	endproperty
	a_stopped: assert property (p_stopped) else $error("zero count did not stop timer"); // see RL18

	property p_level;
		@(posedge clk_i) disable iff (!rst_n_i)
		(tf && countdown_irq_enable && !psel) |=> interrupt_pin_oe_o;
	endproperty
	a_level: assert property (p_level) else $error("level interrupt missing"); // see RL19

	property p_out_bit;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!any_en && !alarm_irq && !wd_irq && !pulse_on) |=> interrupt_pin_oe_o == !$past(out_reg[OUT_BIT]);
	endproperty
	a_out_bit: assert property (p_out_bit) else $error("pin does not follow out bit"); // see RL24

	property p_te_reset;
		@(posedge clk_i)
		!rst_n_i |=> !te && wd_reg == 8'h00;
	endproperty
	a_te_reset: assert property (p_te_reset) else $error("reset left timer or watchdog on"); // see RL22
endmodule : rtc_events

// >>> spi_host.sv
`timescale 1ns/1ns
// ==========
// Host model: serial master, mode 0, 320 ns bit time
module spi_host (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      sck_o,
	output logic      sdi_o,
	output logic      ce_n_o
);
	// Idle bus, deselected
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
		ce_n_o = 1'b1;
	end
	// One byte; reply taken as the clock rises, before the slave may prefetch the next byte
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			sdi_o = tx[b];
			repeat (4) @(negedge clk_i);
			rx[b] = (sdo_oe_i === 1'b1) ? sdo_i : 1'bx;
			sck_o = 1'b1;
			repeat (4) @(negedge clk_i);
			sck_o = 1'b0;
		end
	endtask : xfer
	// Select, then the command byte
	task automatic open(input logic [7:0] cmd);
		logic [7:0] dummy;
		ce_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		xfer(cmd, dummy);
	endtask : open
	// Deselect; idle data shows the inverse of its last bit
	task automatic close();
		repeat (4) @(negedge clk_i);
		ce_n_o = 1'b1;
		sdi_o = ~sdi_o;
		repeat (8) @(negedge clk_i);
	endtask : close
endmodule : spi_host

// >>> rtc_alarm_watchdog_countdown_tb.sv
`timescale 1ns/1ns
module rtc_alarm_watchdog_countdown_tb;
	import rtc_event_pkg::*;
	typedef struct {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_s;
	// ==========
	// Plain rows: write, then read back; 20h is unmapped
	row_s rows [4] = '{'{7'h13, 8'h02, 8'h02}, '{7'h14, 8'h5a, 8'h5a}, '{7'h11, 8'h43, 8'h43},
		'{7'h20, 8'ha5, 8'h00}};
	// Yearly alarm 2/3 04:05:06, first alarm interrupt enabled
	logic [7:0] yr [5] = '{8'h42, 8'h03, 8'h04, 8'h05, 8'h06};
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       osc = 1'b0;
	logic [7:0] sec = 8'h00;
	logic [7:0] tmin = 8'h00, thr = 8'h00, tdate = 8'h01, tmon = 8'h01;
	logic       sck, sdi, ce_n, sdo, sdo_oe, pin_oe;
	logic [7:0] q, q2;
	int         w;
	int         n_mismatch = 0;
	int         comparisons = 0;
	always #20 clk_i = ~clk_i;
	// Scaled tick, 16 cycles a period, so long counts stay short
	always begin
		repeat (8) @(negedge clk_i);
		osc = ~osc;
	end
	rtc_events #(.PULSE_4096_CYC(20), .PULSE_128_CYC(40), .PULSE_64_CYC(80)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_clk_i(sck), .spi_data_i(sdi), .chip_enable_n_i(ce_n),
		.osc_4096_i(osc), .time_sec_i(sec), .time_min_i(tmin), .time_hour_i(thr),
		.time_date_i(tdate), .time_month_i(tmon), .spi_data_o(sdo), .spi_data_oe_o(sdo_oe),
		.interrupt_pin_o(), .interrupt_pin_oe_o(pin_oe));
	spi_host h (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .sdi_o(sdi), .ce_n_o(ce_n));
	// ==========
	// Bus and compare helpers
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		h.open({1'b1, a});
		h.xfer(d, q2);
		h.close();
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		h.open({1'b0, a});
		h.xfer(8'h00, d);
		h.close();
	endtask : rd
	task automatic expect_rd(input logic [6:0] a, input logic [7:0] e);
		rd(a, q);
		check(q, e);
	endtask : expect_rd
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Bounded wait for the pin; w returns the cycles taken
	task automatic wait_pin(input logic lvl, input int bound, output int cyc);
		cyc = 0;
		while (pin_oe !== lvl) begin
			@(negedge clk_i);
			cyc++;
			if (cyc > bound) begin
				n_mismatch++;
				$display("mismatch at %0t: pin wait ran out", $time);
				report_and_stop();
			end
		end
	endtask : wait_pin
	// ==========
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		check({7'h00, pin_oe}, 8'h00);
		expect_rd(ADDR_WD, WD_RST);
		expect_rd(ADDR_CTL, CTL_RST);
		expect_rd(ADDR_A2EN, A2EN_RST);
		expect_rd(ADDR_FLAGS, 8'h00);
		wr(ADDR_OUT, 8'h00);
		check({7'h00, pin_oe}, 8'h01);
		wr(ADDR_OUT, OUT_RST);
		check({7'h00, pin_oe}, 8'h00);
		$display("done reset");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			expect_rd(rows[i].addr, rows[i].exp);
		end
		wr(ADDR_A2EN, 8'h00);
		wr(ADDR_CTL, 8'h00);
		$display("done rows");
		// Watchdog 1 x 1/16 s = 256 ticks, rewritten 2500 cycles after the first write
		wr(ADDR_WD, 8'h04);
		repeat (2500) @(negedge clk_i);
		check({7'h00, pin_oe}, 8'h00);
		wr(ADDR_WD, 8'h04);
		wait_pin(1'b1, 5000, w);
		check({7'h00, w > 3900 && w < 4150}, 8'h01);
		expect_rd(ADDR_FLAGS, 8'h80);
		check({7'h00, pin_oe}, 8'h01);
		wr(ADDR_WD, 8'h00);
		check({7'h00, pin_oe}, 8'h00);
		expect_rd(ADDR_FLAGS, 8'h00);
		$display("done watchdog");
		// Level mode, n = 3 at the fast source
		wr(ADDR_CNT, 8'h03);
		wr(ADDR_CTL, 8'ha0);
		wait_pin(1'b1, 200, w);
		rd(ADDR_CNT, q);
		check({7'h00, q >= 8'h01 && q <= 8'h03}, 8'h01);
		wr(ADDR_CTL, 8'h80);
		check({7'h00, pin_oe}, 8'h00);
		wr(ADDR_CTL, 8'h00);
		rd(ADDR_CNT, q);
		repeat (200) @(negedge clk_i);
		expect_rd(ADDR_CNT, q);
		expect_rd(ADDR_FLAGS, 8'h08);
		expect_rd(ADDR_FLAGS, 8'h00);
		$display("done level");
		// Pulse mode: width, survival of a flag read, stop
		wr(ADDR_CNT, 8'h02);
		wr(ADDR_CTL, 8'he0);
		wait_pin(1'b1, 200, w);
		wait_pin(1'b0, 200, w);
		check(w[7:0], 8'h14);
		expect_rd(ADDR_FLAGS, 8'h08);
		wait_pin(1'b1, 100, w);
		wr(ADDR_CTL, 8'h00);
		wr(ADDR_CNT, 8'h01);
		check({7'h00, pin_oe}, 8'h00);
		wr(ADDR_CTL, 8'he1);
		wait_pin(1'b1, 1200, w);
		wait_pin(1'b0, 100, w);
		check(w[7:0], 8'h28);
		wait_pin(1'b1, 1200, w);
		check({7'h00, w > 970 && w < 1000}, 8'h01);
		wr(ADDR_CTL, 8'h00);
		expect_rd(ADDR_FLAGS, 8'h08);
		$display("done pulse");
		// Both alarms once a second; the second burst parks the pointer on flags
		h.open({1'b1, ADDR_A2EN});
		h.xfer(8'h02, q2);
		for (int i = 0; i < ALARM_REGS; i++) h.xfer(8'h80, q2);
		h.close();
		h.open({1'b1, ADDR_A1});
		h.xfer(8'hc0, q2);
		for (int i = 1; i < ALARM_REGS; i++) h.xfer(8'h80, q2);
		h.close();
		sec = 8'h01;
		repeat (20) @(negedge clk_i);
		check({7'h00, pin_oe}, 8'h00);
		expect_rd(ADDR_A2EN, 8'h02);
		sec = 8'h02;
		wait_pin(1'b1, 20, w);
		expect_rd(ADDR_FLAGS, 8'h60);
		check({7'h00, pin_oe}, 8'h00);
		expect_rd(ADDR_FLAGS, 8'h00);
		// Undefined code 01010 with mismatching fields still fires
		wr(ADDR_A2EN, 8'h00);
		h.open({1'b1, ADDR_A1});
		h.xfer(8'h40, q2);
		h.xfer(8'h80, q2);
		h.xfer(8'h00, q2);
		h.xfer(8'h80, q2);
		h.xfer(8'h05, q2);
		h.close();
		expect_rd(ADDR_A2EN, 8'h00);
		sec = 8'h03;
		wait_pin(1'b1, 20, w);
		expect_rd(ADDR_FLAGS, 8'h40);
		// Yearly alarm: every field must agree, seconds last
		h.open({1'b1, ADDR_A1});
		foreach (yr[i]) h.xfer(yr[i], q2);
		h.close();
		expect_rd(ADDR_A2EN, 8'h00);
		{tmon, tdate, thr, tmin, sec} = {8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
		repeat (20) @(negedge clk_i);
		check({7'h00, pin_oe}, 8'h00);
		sec = 8'h06;
		wait_pin(1'b1, 20, w);
		expect_rd(ADDR_FLAGS, 8'h40);
		$display("done alarm");
		report_and_stop();
	end
endmodule : rtc_alarm_watchdog_countdown_tb
